//--- verilog/jump_branch_pkg.sv
package jump_branch_pkg;
	// Opcodes handled by this unit
	localparam logic [7:0] OP_ABS_JUMP = 8'hc3;
	localparam logic [7:0] OP_REL_JUMP = 8'h18;
	localparam logic [7:0] OP_REL_Z = 8'h28;
	localparam logic [7:0] OP_REL_NC = 8'h30;
	localparam logic [7:0] OP_REL_C = 8'h38;
	// Conditional absolute jump pattern: 11 ccc 010
	localparam logic [1:0] ABS_COND_HI = 2'h3;
	localparam logic [2:0] ABS_COND_LO = 3'h2;
	localparam int ABS_COND_FIELD_LSB = 3;
	// Condition field codes
	localparam logic [2:0] COND_NOT_ZERO = 3'h0;
	localparam logic [2:0] COND_ZERO = 3'h1;
	localparam logic [2:0] COND_NO_CARRY = 3'h2;
	localparam logic [2:0] COND_CARRY = 3'h3;
	localparam logic [2:0] COND_PARITY_ODD = 3'h4;
	localparam logic [2:0] COND_PARITY_EVEN = 3'h5;
	localparam logic [2:0] COND_SIGN_POS = 3'h6;
	localparam logic [2:0] COND_SIGN_NEG = 3'h7;
	// Flag bit positions in the flag byte
	localparam int FLAG_SIGN = 7;
	localparam int FLAG_ZERO = 6;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_CARRY = 0;
	// Clock states per machine cycle, one clock per state
	localparam logic [2:0] T_FETCH = 3'h4;
	localparam logic [2:0] T_READ = 3'h3;
	localparam logic [2:0] T_INTERNAL = 3'h5;
	// Instruction lengths in clock states
	localparam logic [3:0] LEN_ABS = 4'ha;
	localparam logic [3:0] LEN_REL_TAKEN = 4'hc;
	localparam logic [3:0] LEN_REL_SKIP = 4'h7;
	// Reset values
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Sequencer states, Gray coded along fetch, operands, add
	typedef enum logic [1:0] {
		ST_FETCH = 2'h0,
		ST_OPND1 = 2'h1,
		ST_OPND2 = 2'h3,
		ST_REL_ADD = 2'h2
	} state_type;
endpackage

//--- verilog/cond_if.sv
`timescale 1ns/1ps
interface cond_if;
	logic clk;
	logic [2:0] field;
	logic [7:0] flags;
	logic holds;
	modport eval (input clk, input field, input flags, output holds);
	modport user (output clk, output field, output flags, input holds);
endinterface

//--- verilog/cond_eval.sv
`timescale 1ns/1ps
module cond_eval
(
	cond_if.eval cif
);
	// Pick the flag named by the field, odd codes test for set
	function automatic logic cond_true(input logic [2:0] f,
		input logic [7:0] fl);
		logic bit_val;
		bit_val = 1'b0;
		unique case (f[2:1])
			2'h0: bit_val = fl[jump_branch_pkg::FLAG_ZERO];
			2'h1: bit_val = fl[jump_branch_pkg::FLAG_CARRY];
			2'h2: bit_val = fl[jump_branch_pkg::FLAG_PARITY];
			2'h3: bit_val = fl[jump_branch_pkg::FLAG_SIGN];
		endcase
		return f[0] ? bit_val : ~bit_val;
	endfunction

	assign cif.holds = cond_true(cif.field, cif.flags);

	property p_cond_parity_odd;
		@(posedge cif.clk)
		(cif.field == jump_branch_pkg::COND_PARITY_ODD) |->
		(cif.holds == !cif.flags[jump_branch_pkg::FLAG_PARITY]);
	endproperty
	a_cond_parity_odd: assert property (p_cond_parity_odd)
	else $error("Parity odd condition decoded wrongly");
endmodule

//--- verilog/jump_branch_unit.sv
`timescale 1ns/1ps
module jump_branch_unit
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] MEM_DATA,
	input wire logic [7:0] FLAGS,
	output logic [15:0] MEM_ADDR,
	output logic MEM_RD,
	output logic INSTR_DONE,
	output logic BRANCH_TAKEN
);
	jump_branch_pkg::state_type state_reg;
	jump_branch_pkg::state_type state_next;
	logic [2:0] t_reg;
	logic [15:0] pc_reg;
	logic [7:0] op_reg;
	logic [7:0] opnd_reg;
	logic done_reg;
	logic taken_reg;
	logic rd_reg;
	logic end_of_m;
	logic last;
	logic taken_now;
	logic [3:0] len_reg;

	cond_if cif();

	function automatic logic is_abs(input logic [7:0] op);
		return op == jump_branch_pkg::OP_ABS_JUMP ||
			(op[7:6] == jump_branch_pkg::ABS_COND_HI &&
			op[2:0] == jump_branch_pkg::ABS_COND_LO);
	endfunction

	function automatic logic is_rel(input logic [7:0] op);
		return op == jump_branch_pkg::OP_REL_JUMP ||
			op == jump_branch_pkg::OP_REL_Z ||
			op == jump_branch_pkg::OP_REL_NC ||
			op == jump_branch_pkg::OP_REL_C;
	endfunction

	function automatic logic [2:0] rel_field(input logic [7:0] op);
		logic [2:0] f;
		f = jump_branch_pkg::COND_CARRY;
		if (op == jump_branch_pkg::OP_REL_Z)
			f = jump_branch_pkg::COND_ZERO;
		else if (op == jump_branch_pkg::OP_REL_NC)
			f = jump_branch_pkg::COND_NO_CARRY;
		return f;
	endfunction

	// flags read only, no path writes them
	assign cif.flags = FLAGS;
	assign cif.clk = CLK;
	assign cif.field = is_rel(op_reg) ? rel_field(op_reg) :
		op_reg[jump_branch_pkg::ABS_COND_FIELD_LSB +: 3];

	cond_eval u_cond
	(
		.cif(cif)
	);

	// Unconditional forms ignore the evaluated condition
	// always taken
	assign taken_now = (op_reg == jump_branch_pkg::OP_ABS_JUMP ||
		op_reg == jump_branch_pkg::OP_REL_JUMP) ? 1'b1 : cif.holds;

	// Last clock state of the current machine cycle
	always_comb
	begin
		end_of_m = 1'b0;
		unique case (state_reg)
			jump_branch_pkg::ST_FETCH:
				end_of_m = t_reg == jump_branch_pkg::T_FETCH - 3'h1;
			jump_branch_pkg::ST_OPND1,
			jump_branch_pkg::ST_OPND2:
				end_of_m = t_reg == jump_branch_pkg::T_READ - 3'h1;
			jump_branch_pkg::ST_REL_ADD:
				end_of_m = t_reg == jump_branch_pkg::T_INTERNAL - 3'h1;
		endcase
	end

	// Machine cycle sequencing
	always_comb
	begin
		state_next = state_reg;
		last = 1'b0;
		if (end_of_m)
		begin
			unique case (state_reg)
				jump_branch_pkg::ST_FETCH:
					// Other opcodes belong elsewhere; here a bare fetch
					if (is_abs(MEM_DATA) || is_rel(MEM_DATA))
						state_next = jump_branch_pkg::ST_OPND1;
					else
						last = 1'b1;
				jump_branch_pkg::ST_OPND1:
					if (is_rel(op_reg) && taken_now)
						state_next = jump_branch_pkg::ST_REL_ADD;
					else if (is_rel(op_reg))
					begin
						state_next = jump_branch_pkg::ST_FETCH;
						last = 1'b1;
					end
					else
						state_next = jump_branch_pkg::ST_OPND2;
				jump_branch_pkg::ST_OPND2,
				jump_branch_pkg::ST_REL_ADD:
				begin
					state_next = jump_branch_pkg::ST_FETCH;
					last = 1'b1;
				end
			endcase
		end
	end

	// State and clock state counter
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			state_reg <= jump_branch_pkg::ST_FETCH;
			t_reg <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			t_reg <= end_of_m ? 3'h0 : t_reg + 3'h1;
		end
	end

	// Opcode and first operand capture
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			op_reg <= 8'h00;
			opnd_reg <= 8'h00;
		end
		else if (end_of_m && state_reg == jump_branch_pkg::ST_FETCH)
			op_reg <= MEM_DATA;
		else if (end_of_m && state_reg == jump_branch_pkg::ST_OPND1)
			opnd_reg <= MEM_DATA;
	end

	// Program counter
	always_ff @(posedge CLK)
	begin
		if (RESET)
			pc_reg <= jump_branch_pkg::PC_RESET;
		else if (end_of_m)
		begin
			unique case (state_reg)
				jump_branch_pkg::ST_FETCH,
				jump_branch_pkg::ST_OPND1:
					pc_reg <= pc_reg + 16'h0001;
				jump_branch_pkg::ST_OPND2:
					pc_reg <= taken_now ? {MEM_DATA, opnd_reg} :
						pc_reg + 16'h0001;
				jump_branch_pkg::ST_REL_ADD:
					pc_reg <= pc_reg + {{8{opnd_reg[7]}}, opnd_reg};
			endcase
		end
	end

	// Registered outputs; read strobe low only in the internal cycle
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			done_reg <= 1'b0;
			taken_reg <= 1'b0;
			rd_reg <= 1'b1;
		end
		else
		begin
			done_reg <= last;
			taken_reg <= last && taken_now &&
				state_reg != jump_branch_pkg::ST_FETCH;
			rd_reg <= state_next != jump_branch_pkg::ST_REL_ADD;
		end
	end

	assign MEM_ADDR = pc_reg;
	assign MEM_RD = rd_reg;
	assign INSTR_DONE = done_reg;
	assign BRANCH_TAKEN = taken_reg;

	// Clock states since the instruction began, for the checks
	always_ff @(posedge CLK)
	begin
		if (RESET)
			len_reg <= 4'h0;
		else if (state_reg == jump_branch_pkg::ST_FETCH && t_reg == 3'h0)
			len_reg <= 4'h1;
		else
			len_reg <= len_reg + 4'h1;
	end

	property p_abs_len;
		@(posedge CLK) disable iff (RESET)
		(last && is_abs(op_reg) &&
		state_reg != jump_branch_pkg::ST_FETCH) |->
		(len_reg == jump_branch_pkg::LEN_ABS - 4'h1);
	endproperty
	a_abs_len: assert property (p_abs_len)
	else $error("Absolute jump length wrong");

	property p_abs_target;
		@(posedge CLK) disable iff (RESET)
		(last && state_reg == jump_branch_pkg::ST_OPND2 && taken_now) |=>
		(MEM_ADDR == {$past(MEM_DATA), $past(opnd_reg)}) && BRANCH_TAKEN;
	endproperty
	a_abs_target: assert property (p_abs_target)
	else $error("Absolute target not loaded");

	property p_abs_skip;
		@(posedge CLK) disable iff (RESET)
		(last && state_reg == jump_branch_pkg::ST_OPND2 && !taken_now) |=>
		(MEM_ADDR == $past(pc_reg) + 16'h0001) && !BRANCH_TAKEN;
	endproperty
	a_abs_skip: assert property (p_abs_skip)
	else $error("Untaken absolute jump did not step");

	property p_cond_form;
		@(posedge CLK) disable iff (RESET)
		(state_reg == jump_branch_pkg::ST_FETCH && end_of_m &&
		MEM_DATA[7:6] == 2'h3 && MEM_DATA[2:0] == 3'h2) |=>
		(state_reg == jump_branch_pkg::ST_OPND1) ##3
		(state_reg == jump_branch_pkg::ST_OPND2);
	endproperty
	a_cond_form: assert property (p_cond_form)
	else $error("Conditional absolute opcode not decoded");

	property p_rel_target;
		@(posedge CLK) disable iff (RESET)
		(last && state_reg == jump_branch_pkg::ST_REL_ADD) |=>
		(MEM_ADDR == $past(pc_reg) + {{8{$past(opnd_reg[7])}},
		$past(opnd_reg)});
	endproperty
	a_rel_target: assert property (p_rel_target)
	else $error("Relative target wrong");

	property p_rel_taken_len;
		@(posedge CLK) disable iff (RESET)
		(last && state_reg == jump_branch_pkg::ST_REL_ADD) |->
		(len_reg == jump_branch_pkg::LEN_REL_TAKEN - 4'h1) && !MEM_RD;
	endproperty
	a_rel_taken_len: assert property (p_rel_taken_len)
	else $error("Taken relative jump length wrong");

	property p_rel_skip_len;
		@(posedge CLK) disable iff (RESET)
		(last && state_reg == jump_branch_pkg::ST_OPND1) |->
		(len_reg == jump_branch_pkg::LEN_REL_SKIP - 4'h1);
	endproperty
	a_rel_skip_len: assert property (p_rel_skip_len)
	else $error("Untaken relative jump length wrong");

	property p_rel_c;
		@(posedge CLK) disable iff (RESET)
		(end_of_m && state_reg == jump_branch_pkg::ST_OPND1 &&
		op_reg == jump_branch_pkg::OP_REL_C) |=>
		(state_reg == jump_branch_pkg::ST_REL_ADD) ==
		$past(FLAGS[jump_branch_pkg::FLAG_CARRY]);
	endproperty
	a_rel_c: assert property (p_rel_c)
	else $error("Carry set relative jump wrong");

	property p_rel_nc;
		@(posedge CLK) disable iff (RESET)
		(end_of_m && state_reg == jump_branch_pkg::ST_OPND1 &&
		op_reg == jump_branch_pkg::OP_REL_NC) |=>
		(state_reg == jump_branch_pkg::ST_REL_ADD) !=
		$past(FLAGS[jump_branch_pkg::FLAG_CARRY]);
	endproperty
	a_rel_nc: assert property (p_rel_nc)
	else $error("Carry clear relative jump wrong");

	property p_rel_z;
		@(posedge CLK) disable iff (RESET)
		(end_of_m && state_reg == jump_branch_pkg::ST_OPND1 &&
		op_reg == jump_branch_pkg::OP_REL_Z) |=>
		(state_reg == jump_branch_pkg::ST_REL_ADD) ==
		$past(FLAGS[jump_branch_pkg::FLAG_ZERO]);
	endproperty
	a_rel_z: assert property (p_rel_z)
	else $error("Zero set relative jump wrong");
endmodule

//--- tb/prog_memory.sv
`timescale 1ns/1ps
// Program memory with no wait states, read combinationally
module prog_memory
(
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic rd,
	output logic [7:0] data
);
	logic [7:0] store [0:65535];
	logic [7:0] last_reg;

	// Remember the last byte handed out while reading
	always_ff @(posedge clk)
	begin
		if (rd)
			last_reg <= store[addr];
	end

	// Released bus shows the inverse, so stale data cannot pass as valid
	assign data = rd ? store[addr] : ~last_reg;
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic [7:0] FLAGS = 8'h00;
	logic [15:0] MEM_ADDR;
	logic [7:0] MEM_DATA;
	logic MEM_RD;
	logic INSTR_DONE;
	logic BRANCH_TAKEN;
	logic [15:0] pc = 16'h0000;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;

	jump_branch_unit dut (.CLK(CLK), .RESET(RESET), .MEM_DATA(MEM_DATA),
		.FLAGS(FLAGS), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
		.INSTR_DONE(INSTR_DONE), .BRANCH_TAKEN(BRANCH_TAKEN));
	prog_memory mem (.clk(CLK), .addr(MEM_ADDR), .rd(MEM_RD),
		.data(MEM_DATA));

	// Free-running 100 MHz clock
	always #5 CLK = ~CLK;

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			stop_test;
		end
	end

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask

	// Runs one instruction from pc; entered at the negedge of its state 0
	task automatic exec(input logic [7:0] op, input logic [7:0] b1,
		input logic [7:0] b2, input logic [7:0] fl, input logic [15:0] exp_pc,
		input int exp_len, input logic exp_tk, input int exp_idle);
		int n;
		int idle;
		n = 0;
		idle = 0;
		mem.store[pc] = op;
		mem.store[pc + 16'h0001] = b1;
		mem.store[pc + 16'h0002] = b2;
		FLAGS = fl;
		check("fetch address", MEM_ADDR, pc);
		do
		begin
			@(negedge CLK);
			n++;
			if (MEM_RD !== 1'b1)
				idle++;
		end
		while (INSTR_DONE !== 1'b1 && n < 20);
		check("state count", 16'(n), 16'(exp_len));
		check("next address", MEM_ADDR, exp_pc);
		check("branch taken", 16'(BRANCH_TAKEN), 16'(exp_tk));
		check("idle cycles", 16'(idle), 16'(exp_idle));
		pc = exp_pc;
	endtask

	task automatic t_abs_jump;
		exec(8'hc3, 8'h34, 8'h12, 8'h00, 16'h1234, 10, 1'b1, 0);
		exec(8'hc3, 8'h00, 8'hff, 8'hff, 16'hff00, 10, 1'b1, 0);
	endtask

	// every condition code, held and not held
	task automatic t_abs_cond;
		logic [7:0] op;
		logic [7:0] fl;
		int pos;
		for (int cc = 0; cc < 8; cc++)
		begin
			op = 8'hc2 | 8'(cc << 3);
			pos = (cc < 2) ? jump_branch_pkg::FLAG_ZERO :
				(cc < 4) ? jump_branch_pkg::FLAG_CARRY :
				(cc < 6) ? jump_branch_pkg::FLAG_PARITY :
				jump_branch_pkg::FLAG_SIGN;
			fl = (cc % 2 == 1) ? 8'(1 << pos) : 8'h00;
			exec(op, 8'(cc), 8'h20, fl, {8'h20, 8'(cc)}, 10, 1'b1, 0);
			exec(op, 8'h55, 8'h66, ~fl, pc + 16'h0003, 10, 1'b0, 0);
		end
	endtask

	task automatic t_rel_jump;
		exec(8'h18, 8'h7f, 8'h00, 8'h00, pc + 16'h0081, 12, 1'b1, 5);
		exec(8'h18, 8'h80, 8'h00, 8'hff, pc - 16'h007e, 12, 1'b1, 5);
	endtask

	task automatic t_rel_cond;
		logic [7:0] c;
		logic [7:0] z;
		c = 8'(1 << jump_branch_pkg::FLAG_CARRY);
		z = 8'(1 << jump_branch_pkg::FLAG_ZERO);
		exec(8'h38, 8'hfa, 8'h00, c, pc - 16'h0004, 12, 1'b1, 5);
		exec(8'h38, 8'hfa, 8'h00, ~c, pc + 16'h0002, 7, 1'b0, 0);
		exec(8'h30, 8'h03, 8'h00, ~c, pc + 16'h0005, 12, 1'b1, 5);
		exec(8'h30, 8'h03, 8'h00, c, pc + 16'h0002, 7, 1'b0, 0);
		exec(8'h28, 8'h03, 8'h00, z, pc + 16'h0005, 12, 1'b1, 5);
		exec(8'h28, 8'h03, 8'h00, ~z, pc + 16'h0002, 7, 1'b0, 0);
	endtask

	// Reset in the middle of an absolute jump restarts at address zero
	task automatic t_reset_mid;
		mem.store[pc] = 8'hc3;
		repeat (5) @(negedge CLK);
		RESET = 1'b1;
		@(negedge CLK);
		check("reset address", MEM_ADDR, 16'h0000);
		check("reset read", 16'(MEM_RD), 16'h0001);
		check("reset done", 16'(INSTR_DONE), 16'h0000);
		RESET = 1'b0;
		pc = 16'h0000;
		exec(8'hc3, 8'h40, 8'h00, 8'h00, 16'h0040, 10, 1'b1, 0);
	endtask

	// Main sequence; other opcodes act as one-byte, four-state fetches
	initial
	begin
		repeat (6) @(negedge CLK);
		RESET = 1'b0;
		t_abs_jump;
		t_abs_cond;
		t_rel_jump;
		t_rel_cond;
		exec(8'h00, 8'h00, 8'h00, 8'h00, pc + 16'h0001, 4, 1'b0, 0);
		t_reset_mid;
		stop_test;
	end
endmodule
